/* File: hw/fcs_consts.svh */
// constants of the flash command and status sequencer: opcodes,
// status bit positions, timing figures and derived cycle counts.
// assumes a 125 MHz ref_clk; included by bare name from hw/.
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// clock rate
`define FCS_CLK_MHZ 125

// first-write opcodes
`define FCS_OP_RD_ARRAY 8'hFF
`define FCS_OP_RD_STATUS 8'h70
`define FCS_OP_RD_SIG_A 8'h90
`define FCS_OP_RD_SIG_B 8'h98
`define FCS_OP_CLR_STATUS 8'h50
`define FCS_OP_SUSPEND 8'hB0
`define FCS_OP_RESUME 8'hD0
`define FCS_OP_PROG_A 8'h40
`define FCS_OP_PROG_B 8'h10
`define FCS_OP_QUAD 8'h30
`define FCS_OP_BERASE 8'h20
`define FCS_OP_CERASE 8'h80

// second-write confirm codes
`define FCS_CF_BERASE 8'hD0
`define FCS_CF_CERASE 8'h10

// status bit positions
`define FCS_SR_READY 7
`define FCS_SR_ESUSP 6
`define FCS_SR_EFAIL 5
`define FCS_SR_PFAIL 4
`define FCS_SR_VPP 3
`define FCS_SR_PSUSP 2
`define FCS_SR_PROT 1

// program/erase durations in their own units
`define FCS_PROG_TIME_US 10
`define FCS_BERASE_TIME_MS 1000
`define FCS_CERASE_TIME_MS 5000

// longest suspend-to-pause delays, rounded down to whole cycles
`define FCS_PROG_PAUSE_US 5
`define FCS_ERASE_PAUSE_US 30
`define FCS_PROG_PAUSE_CYC (`FCS_PROG_PAUSE_US * `FCS_CLK_MHZ)
`define FCS_ERASE_PAUSE_CYC (`FCS_ERASE_PAUSE_US * `FCS_CLK_MHZ)

// signature codes, values arbitrary
`define FCS_SIG_MFR 8'hA5
`define FCS_SIG_DEV 8'h5A

`endif

/* File: hw/fcs_pkg.sv */
// types shared by the flash command and status sequencer.
// no surroundings assumed.
package fcs_pkg;

  // what a bus read returns
  typedef enum logic [1:0] {
    RM_ARRAY,
    RM_STATUS,
    RM_SIG
  } fcs_rmode_e;

  // which multi-write command awaits its next write
  typedef enum logic [2:0] {
    PD_NONE,
    PD_PROG,
    PD_QUAD,
    PD_BERASE,
    PD_CERASE
  } fcs_pend_e;

endpackage

/* File: hw/fcs_op_timer.sv */
// down-counter standing in for the duration of one program or erase.
// assumes load is a one-cycle pulse and load_val is at least one.
`timescale 1ns/1ns
module fcs_op_timer #(
  parameter int W = 32
) (
  // clock and synchronised reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  // completion pulse
  output logic done_r
);

  logic [W-1:0] count_r;
  wire last_w = run && (count_r == W'(1));

  if (W < 2) begin : g_chk
    $error("fcs_op_timer: W too small");
  end

  // paused by dropping run; the count is kept so a resume continues
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= last_w;
      if (load) begin
        count_r <= load_val;
      end else if (run && count_r != '0) begin
        count_r <= count_r - W'(1);
      end
    end
  end

endmodule

/* File: hw/fcs_sequencer.sv */
// command interpreter and program/erase sequencer of a byte-wide flash.
// assumes bus strobes are one-cycle pulses synchronous to ref_clk, and
// that array_rdata shows the byte at bus_addr in the cycle of bus_rd.
//
// Notes on behaviour
// - first-write codes decode into read, clear, suspend, resume, erase, program.
// - status bit 7 is zero while the controller runs, one otherwise.
// - program takes two writes; second captures, starts, selects status reads.
// - after read-array, reads return array data until another command.
// - after read-status, reads return status until another command.
// - after signature command, reads return codes by address until another command.
// - four-byte program only in multiplexed mode; addresses differ in low bits.
// - chip erase multiplexed only; while running only read-status accepted.
// - finished chip erase leaves the whole array at ones.
// - block erase takes two writes; second captures block, starts, status reads.
// - in low-pin-count mode, erase of a protected block aborts unchanged and flags the failure.
// - during block erase only status and suspend accepted; block ends all ones.
// - clear-status zeroes bits 1, 3, 4, 5 and keeps the read mode.
// - error bits stay set across new operations until cleared.
// - suspend pauses; nothing accepted until paused; reads return status.
// - pause within 5 us for program, 30 us for block erase.
// - operation may finish first; suspend bits tell finish from pause.
// - suspended: read modes and resume accepted; program if erase suspended.
// - resume restarts the controller; reads return status.
// - bit 3 supply, bit 4 program, bit 5 erase failure, bit 2 program suspended.
// - bit 1 set on protected target only in low-pin-count mode.
// - bit 6 marks suspended erase and programs run during it.
`timescale 1ns/1ns
`include "fcs_consts.svh"
module fcs_sequencer #(
  parameter int AW = 19,
  parameter int TW = 32,
  parameter int PROG_CYC = `FCS_PROG_TIME_US * `FCS_CLK_MHZ,
  parameter int BERASE_CYC = `FCS_BERASE_TIME_MS * `FCS_CLK_MHZ * 1000,
  parameter int CERASE_CYC = `FCS_CERASE_TIME_MS * `FCS_CLK_MHZ * 1000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // host bus cycles
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [AW-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] rd_data_r,
  // configuration and protection
  input wire logic mux_mode,
  input wire logic blk_protected,
  input wire logic vpp_low,
  // memory array
  input wire logic [7:0] array_rdata,
  input wire logic cell_fail,
  output logic arr_wr_r,
  output logic [AW-1:0] arr_addr_r,
  output logic [7:0] arr_data_r,
  output logic arr_blk_erase_r,
  output logic arr_chip_erase_r
);

  localparam int PPAUSE = `FCS_PROG_PAUSE_CYC;
  localparam int EPAUSE = `FCS_ERASE_PAUSE_CYC;

  if (AW < 2 || PROG_CYC < 1 || BERASE_CYC < 1 || CERASE_CYC < 1 ||
      TW < 13 || TW > 32) begin : g_chk
    $error("fcs_sequencer: parameter out of range");
  end

  function automatic logic is_op(input logic [7:0] d, input logic [7:0] c);
    return d == c;
  endfunction

  // reset release
  logic rst_q1_r, rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n <= rst_q1_r;
    end
  end

  fcs_pkg::fcs_rmode_e rmode_r, rmode_nxt;
  fcs_pkg::fcs_pend_e pend_r, pend_nxt;
  logic prog_run_r, erase_run_r, prog_susp_r, erase_susp_r;
  logic cerase_r, quad_r, susp_pend_r;
  logic sr1_r, sr3_r, sr4_r, sr5_r;
  logic [TW-1:0] susp_cnt_r;
  logic [1:0] q_idx_r, cm_idx_r;
  logic [2:0] cm_left_r;
  logic [AW-1:0] q_addr_r [4];
  logic [7:0] q_data_r [4];
  logic [AW-1:0] er_addr_r;
  logic prog_done, erase_done;

  // controller state seen by the host
  wire running = prog_run_r | erase_run_r;
  wire suspended = !running && (prog_susp_r || erase_susp_r);
  wire idle = !running && !prog_susp_r && !erase_susp_r;
  wire [7:0] status_w = {~running, erase_susp_r, sr5_r, sr4_r, sr3_r,
                         prog_susp_r, sr1_r, 1'b0};

  // first-write decode; nothing is taken while a pause is pending
  wire acc_wr = bus_wr && pend_r == fcs_pkg::PD_NONE && !susp_pend_r;
  wire [7:0] op = bus_wdata;
  wire c_status = acc_wr && is_op(op, `FCS_OP_RD_STATUS);
  wire c_array = acc_wr && !running &&
                 is_op(op, `FCS_OP_RD_ARRAY);
  wire c_sig = acc_wr && !running && (is_op(op, `FCS_OP_RD_SIG_A) ||
               is_op(op, `FCS_OP_RD_SIG_B));
  wire c_clear = acc_wr && idle && is_op(op, `FCS_OP_CLR_STATUS);
  // cerase_r outlives its erase, so a later program must still be pausable
  wire c_susp = acc_wr && running && !(cerase_r && erase_run_r) &&
                is_op(op, `FCS_OP_SUSPEND);
  wire c_resume = acc_wr && suspended &&
                  is_op(op, `FCS_OP_RESUME);
  wire c_prog = acc_wr && (idle || (suspended && erase_susp_r &&
                !prog_susp_r)) && (is_op(op, `FCS_OP_PROG_A) ||
                is_op(op, `FCS_OP_PROG_B));
  wire c_quad = acc_wr && idle && mux_mode &&
                is_op(op, `FCS_OP_QUAD);
  wire c_berase = acc_wr && idle && is_op(op, `FCS_OP_BERASE);
  wire c_cerase = acc_wr && idle && mux_mode &&
                  is_op(op, `FCS_OP_CERASE);

  // later writes of multi-write commands
  wire s_prog = bus_wr && pend_r == fcs_pkg::PD_PROG;
  wire s_quad = bus_wr && pend_r == fcs_pkg::PD_QUAD;
  wire s_quad_last = s_quad && q_idx_r == 2'd3;
  wire s_berase = bus_wr && pend_r == fcs_pkg::PD_BERASE &&
                  is_op(op, `FCS_CF_BERASE);
  wire s_cerase = bus_wr && pend_r == fcs_pkg::PD_CERASE &&
                  is_op(op, `FCS_CF_CERASE);
  wire second = s_prog || s_quad_last || s_berase || s_cerase;

  // protection is only reported on the low-pin-count interface
  wire prot = blk_protected && !mux_mode;
  wire prot_hit = (s_prog || s_berase) && prot;
  wire vpp_hit = second && !prot_hit && vpp_low;
  wire start_prog = (s_prog || s_quad_last) && !prot_hit && !vpp_low;
  wire start_berase = s_berase && !prot && !vpp_low;
  wire start_cerase = s_cerase && !vpp_low;

  // suspend latency: the pause lands at the longest allowed delay
  wire [TW-1:0] pause_lat = prog_run_r ? TW'(PPAUSE) : TW'(EPAUSE);
  wire op_done = prog_done || erase_done;
  wire pause_now = susp_pend_r && !op_done &&
                   susp_cnt_r == pause_lat - TW'(1);

  // read mode
  always_comb begin
    rmode_nxt = rmode_r;
    if (c_array) rmode_nxt = fcs_pkg::RM_ARRAY;
    else if (c_sig) rmode_nxt = fcs_pkg::RM_SIG;
    else if (c_status || c_susp || c_resume || second || prot_hit)
      rmode_nxt = fcs_pkg::RM_STATUS;
  end

  // pending multi-write command; a bad confirm code drops it
  always_comb begin
    pend_nxt = pend_r;
    if (c_prog) pend_nxt = fcs_pkg::PD_PROG;
    else if (c_quad) pend_nxt = fcs_pkg::PD_QUAD;
    else if (c_berase) pend_nxt = fcs_pkg::PD_BERASE;
    else if (c_cerase) pend_nxt = fcs_pkg::PD_CERASE;
    else if (bus_wr && !(s_quad && !s_quad_last))
      pend_nxt = fcs_pkg::PD_NONE;
  end

  fcs_op_timer #(.W(TW)) u_prog_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(start_prog),
    .load_val(TW'(PROG_CYC)),
    .run(prog_run_r),
    .done_r(prog_done)
  );

  fcs_op_timer #(.W(TW)) u_erase_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(start_berase || start_cerase),
    .load_val(start_cerase ? TW'(CERASE_CYC) : TW'(BERASE_CYC)),
    .run(erase_run_r),
    .done_r(erase_done)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rmode_r <= fcs_pkg::RM_ARRAY;
      pend_r <= fcs_pkg::PD_NONE;
    end else begin
      rmode_r <= rmode_nxt;
      pend_r <= pend_nxt;
    end
  end

  // controller run and suspend flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_run_r <= 1'b0;
      erase_run_r <= 1'b0;
      prog_susp_r <= 1'b0;
      erase_susp_r <= 1'b0;
      cerase_r <= 1'b0;
      susp_pend_r <= 1'b0;
      susp_cnt_r <= '0;
    end else begin
      if (start_prog) prog_run_r <= 1'b1;
      else if (prog_done || (pause_now && prog_run_r)) prog_run_r <= 1'b0;
      else if (c_resume && prog_susp_r) prog_run_r <= 1'b1;
      if (start_berase || start_cerase) begin
        erase_run_r <= 1'b1;
        cerase_r <= start_cerase;
      end else if (erase_done || (pause_now && !prog_run_r)) begin
        erase_run_r <= 1'b0;
      end else if (c_resume && !prog_susp_r) begin
        erase_run_r <= 1'b1;
      end
      if (pause_now && prog_run_r) prog_susp_r <= 1'b1;
      else if (c_resume && prog_susp_r) prog_susp_r <= 1'b0;
      if (pause_now && !prog_run_r) erase_susp_r <= 1'b1;
      else if (c_resume && !prog_susp_r) erase_susp_r <= 1'b0;
      if (c_susp) begin
        susp_pend_r <= 1'b1;
        susp_cnt_r <= '0;
      end else if (pause_now || op_done) begin
        susp_pend_r <= 1'b0;
      end else if (susp_pend_r) begin
        susp_cnt_r <= susp_cnt_r + TW'(1);
      end
    end
  end

  // sticky error bits; an event in the same cycle as a clear wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr1_r <= 1'b0;
      sr3_r <= 1'b0;
      sr4_r <= 1'b0;
      sr5_r <= 1'b0;
    end else begin
      sr1_r <= (sr1_r && !c_clear) || prot_hit;
      sr3_r <= (sr3_r && !c_clear) || vpp_hit;
      sr4_r <= (sr4_r && !c_clear) || (prog_done && cell_fail);
      sr5_r <= (sr5_r && !c_clear) || (erase_done && cell_fail);
    end
  end

  // capture of program bytes and erase block
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_idx_r <= 2'd0;
      quad_r <= 1'b0;
      er_addr_r <= '0;
    end else begin
      if (c_prog || c_quad) begin
        q_idx_r <= 2'd0;
        quad_r <= c_quad;
      end else if (s_quad) begin
        q_idx_r <= q_idx_r + 2'd1;
      end
      if (s_berase) er_addr_r <= bus_addr;
    end
  end

  // byte store has no reset: contents only matter once captured
  always_ff @(posedge ref_clk) begin
    if (s_prog || s_quad) begin
      q_addr_r[s_prog ? 2'd0 : q_idx_r] <= bus_addr;
      q_data_r[s_prog ? 2'd0 : q_idx_r] <= bus_wdata;
    end
  end

  // array commit; bytes reach the array only after a clean finish
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cm_left_r <= 3'd0;
      cm_idx_r <= 2'd0;
      arr_wr_r <= 1'b0;
      arr_addr_r <= '0;
      arr_data_r <= 8'h00;
      arr_blk_erase_r <= 1'b0;
      arr_chip_erase_r <= 1'b0;
    end else begin
      arr_wr_r <= cm_left_r != 3'd0;
      arr_blk_erase_r <= erase_done && !cell_fail && !cerase_r;
      arr_chip_erase_r <= erase_done && !cell_fail && cerase_r;
      if (prog_done && !cell_fail) begin
        cm_left_r <= quad_r ? 3'd4 : 3'd1;
        cm_idx_r <= 2'd0;
      end else if (cm_left_r != 3'd0) begin
        cm_left_r <= cm_left_r - 3'd1;
        cm_idx_r <= cm_idx_r + 2'd1;
      end
      if (cm_left_r != 3'd0) begin
        arr_addr_r <= q_addr_r[cm_idx_r];
        arr_data_r <= q_data_r[cm_idx_r];
      end else if (erase_done) begin
        arr_addr_r <= er_addr_r;
      end
    end
  end

  // read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (bus_rd) begin
      if (rmode_r == fcs_pkg::RM_ARRAY) rd_data_r <= array_rdata;
      else if (rmode_r == fcs_pkg::RM_STATUS) rd_data_r <= status_w;
      else if (bus_addr[0]) rd_data_r <= `FCS_SIG_DEV;
      else rd_data_r <= `FCS_SIG_MFR;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  localparam int EPAUSE_I = EPAUSE;
  logic [TW-1:0] pend_age_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pend_age_r <= '0;
    else if (!susp_pend_r) pend_age_r <= '0;
    else pend_age_r <= pend_age_r + TW'(1);
  end

  property p_busy_bit;
    bus_rd && rmode_r == fcs_pkg::RM_STATUS |=>
      rd_data_r[7] == !$past(running);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("bit7 wrong");

  property p_status_read;
    bus_rd && rmode_r == fcs_pkg::RM_STATUS |=>
      rd_data_r == $past(status_w);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_array_read;
    bus_rd && rmode_r == fcs_pkg::RM_ARRAY |=>
      rd_data_r == $past(array_rdata);
  endproperty
  a_array_read: assert property (p_array_read)
    else $error("array read wrong");

  property p_sig_read;
    bus_rd && rmode_r == fcs_pkg::RM_SIG && !bus_addr[0] |=>
      rd_data_r == `FCS_SIG_MFR;
  endproperty
  a_sig_read: assert property (p_sig_read)
    else $error("signature read wrong");

  property p_prog_start;
    s_prog && !prot && !vpp_low |=>
      prog_run_r && rmode_r == fcs_pkg::RM_STATUS && !status_w[7];
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("program not started");

  property p_cerase_lock;
    cerase_r && erase_run_r && bus_wr &&
      !is_op(bus_wdata, `FCS_OP_RD_STATUS) |=>
      $stable(rmode_r) && !susp_pend_r;
  endproperty
  a_cerase_lock: assert property (p_cerase_lock)
    else $error("command taken in chip erase");

  property p_prot_abort;
    s_berase && blk_protected && !mux_mode |=>
      sr1_r && !erase_run_r ##1 !arr_blk_erase_r;
  endproperty
  a_prot_abort: assert property (p_prot_abort)
    else $error("protected erase ran");

  property p_clear;
    c_clear |=> !sr1_r && !sr3_r && !sr4_r && !sr5_r && $stable(rmode_r);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_pause_bound;
    susp_pend_r |->
      pend_age_r < (prog_run_r ? TW'(PPAUSE) : TW'(EPAUSE_I));
  endproperty
  a_pause_bound: assert property (p_pause_bound)
    else $error("pause too late");

  property p_esusp_bits;
    $rose(erase_susp_r) |-> status_w[6] && status_w[7] && !status_w[2];
  endproperty
  a_esusp_bits: assert property (p_esusp_bits)
    else $error("erase suspend bits wrong");

  property p_sticky;
    sr4_r && !c_clear |=> sr4_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("bit4 lost");

  c_prog_done: cover property (prog_done && !cell_fail ##2 arr_wr_r);
  c_erase_susp: cover property ($rose(erase_susp_r));
  c_resume_cov: cover property (c_resume);
  c_chip: cover property (arr_chip_erase_r);

endmodule

/* File: dv/fcs_array_model.sv */
// byte-wide memory array model facing the sequencer's array port.
// assumes one-cycle update pulses and a combinational read at rd_addr.
`timescale 1ns/1ns
module fcs_array_model #(
  parameter int AW = 8,
  parameter int BLK_BITS = 4
) (
  // clock
  input wire logic ref_clk,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_byte,
  // update pulses
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_byte,
  input wire logic blk_erase,
  input wire logic chip_erase
);
  logic [7:0] mem [2**AW];

  // seeded with a pattern so an erase is visible wherever the low address byte is not C3h
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
  end

  assign rd_byte = mem[rd_addr];

  // programming only clears bits; only an erase brings ones back
  always @(posedge ref_clk) begin
    for (int i = 0; i < 2**AW; i++) begin
      if (chip_erase || (blk_erase && (i >> BLK_BITS) ==
          (int'(wr_addr) >> BLK_BITS))) begin
        mem[i] <= 8'hFF;
      end
    end
    if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] & wr_byte;
    end
  end
endmodule

/* File: dv/fcs_sequencer_tb_top.sv */
// self-checking bench of the flash command and status sequencer.
// assumes the array model beside it and shortened operation times.
`timescale 1ns/1ns
module fcs_sequencer_tb_top;
  localparam int AW = 8;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [AW-1:0] bus_addr = '0;
  logic [7:0] bus_wdata = 8'h00;
  logic mux_mode = 1'b0;
  logic blk_protected = 1'b0;
  logic vpp_low = 1'b0;
  logic cell_fail = 1'b0;
  logic [7:0] rd_data_r, array_rdata, arr_data_r;
  logic [AW-1:0] arr_addr_r;
  logic arr_wr_r, arr_blk_erase_r, arr_chip_erase_r;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0;

  always #4 ref_clk = ~ref_clk;

  fcs_sequencer #(.AW(AW), .PROG_CYC(800), .BERASE_CYC(5000),
    .CERASE_CYC(300)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .rd_data_r(rd_data_r),
    .mux_mode(mux_mode), .blk_protected(blk_protected),
    .vpp_low(vpp_low), .array_rdata(array_rdata), .cell_fail(cell_fail),
    .arr_wr_r(arr_wr_r), .arr_addr_r(arr_addr_r), .arr_data_r(arr_data_r),
    .arr_blk_erase_r(arr_blk_erase_r), .arr_chip_erase_r(arr_chip_erase_r));

  fcs_array_model #(.AW(AW)) mem_u (
    .ref_clk(ref_clk), .rd_addr(bus_addr), .rd_byte(array_rdata),
    .wr_en(arr_wr_r), .wr_addr(arr_addr_r), .wr_byte(arr_data_r),
    .blk_erase(arr_blk_erase_r), .chip_erase(arr_chip_erase_r));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang counts as a mismatch before the report
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [7:0] got,
    input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    // taken one edge later, where the registered answer has settled
    @(posedge ref_clk);
    d = rd_data_r;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask

  // polls bit 7 with a bounded number of reads
  task automatic wait_ready();
    logic [7:0] v;
    for (int i = 0; i < 4000; i++) begin
      rd(8'h00, v);
      if (v[7] === 1'b1) begin
        return;
      end
    end
    chk("ready", v, 8'h80);
  endtask

  task automatic t_reset();
    rdchk("array after reset", 8'h05, 8'h39);
    wr(8'h00, 8'h70);
    rdchk("status after reset", 8'h00, 8'h80);
    $display("reset test done");
  endtask

  task automatic t_sig();
    logic [7:0] op [2] = '{8'h90, 8'h98};
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, op[i]);
      rdchk("manufacturer code", 8'h00, 8'hA5);
      rdchk("device code", 8'h01, 8'h5A);
    end
    wr(8'h00, 8'hFF);
    rdchk("array read", 8'h07, 8'h3B);
    $display("signature test done");
  endtask

  task automatic t_prog();
    logic [7:0] op [2] = '{8'h40, 8'h10};
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, op[i]);
      wr(8'h10 + 8'(i), 8'h5A);
      rdchk("status while programming", 8'h00, 8'h00);
      wait_ready();
      rdchk("status after program", 8'h00, 8'h80);
      wr(8'h00, 8'hFF);
      rdchk("programmed byte", 8'h10 + 8'(i), 8'h08);
    end
    $display("program test done");
  endtask

  task automatic t_errors();
    vpp_low <= 1'b1;
    wr(8'h00, 8'h40);
    wr(8'h12, 8'h00);
    wait_ready();
    rdchk("supply error", 8'h00, 8'h88);
    vpp_low <= 1'b0;
    cell_fail <= 1'b1;
    wr(8'h00, 8'h40);
    wr(8'h12, 8'h00);
    wait_ready();
    rdchk("sticky errors", 8'h00, 8'h98);
    cell_fail <= 1'b0;
    wr(8'h00, 8'h50);
    rdchk("status after clear", 8'h00, 8'h80);
    wr(8'h00, 8'hFF);
    rdchk("failed program leaves byte", 8'h12, 8'h2E);
    wr(8'h00, 8'h50);
    rdchk("clear keeps array mode", 8'h13, 8'h2F);
    $display("error bits test done");
  endtask

  task automatic t_berase();
    blk_protected <= 1'b1;
    wr(8'h00, 8'h20);
    wr(8'h20, 8'hD0);
    wait_ready();
    rdchk("protection flag", 8'h00, 8'h82);
    blk_protected <= 1'b0;
    wr(8'h00, 8'hFF);
    rdchk("protected block kept", 8'h21, 8'h1D);
    wr(8'h00, 8'h50);
    wr(8'h00, 8'h20);
    wr(8'h20, 8'hD0);
    wr(8'h00, 8'hFF);
    rdchk("erase ignores array command", 8'h00, 8'h00);
    wait_ready();
    wr(8'h00, 8'hFF);
    rdchk("erased low byte", 8'h20, 8'hFF);
    rdchk("erased high byte", 8'h2F, 8'hFF);
    rdchk("next block kept", 8'h30, 8'h0C);
    $display("block erase test done");
  endtask

  task automatic t_suspend();
    wr(8'h00, 8'h20);
    wr(8'h40, 8'hD0);
    wr(8'h00, 8'hB0);
    t0 = cyc;
    wr(8'h00, 8'hFF);
    wait_ready();
    chk("erase pause in time", 8'(cyc - t0 <= 3760), 8'h01);
    rdchk("erase suspended", 8'h00, 8'hC0);
    wr(8'h00, 8'h40);
    wr(8'h50, 8'h77);
    wait_ready();
    rdchk("program in erase suspend", 8'h00, 8'hC0);
    wr(8'h00, 8'hD0);
    rdchk("resumed erase runs", 8'h00, 8'h00);
    wait_ready();
    wr(8'h00, 8'hFF);
    rdchk("resumed block erased", 8'h40, 8'hFF);
    rdchk("byte programmed in suspend", 8'h50, 8'h64);
    wr(8'h00, 8'h40);
    wr(8'h70, 8'h0F);
    wr(8'h00, 8'hB0);
    t0 = cyc;
    wait_ready();
    chk("program pause in time", 8'(cyc - t0 <= 635), 8'h01);
    rdchk("program suspended", 8'h00, 8'h84);
    wr(8'h00, 8'hD0);
    wait_ready();
    rdchk("program finished", 8'h00, 8'h80);
    wr(8'h00, 8'hFF);
    rdchk("resumed program byte", 8'h70, 8'h0C);
    $display("suspend test done");
  endtask

  task automatic t_chip();
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h10);
    rdchk("chip erase refused", 8'h05, 8'h39);
    // 10h alone opened a program; all-ones data finishes it harmlessly
    wr(8'h00, 8'hFF);
    wait_ready();
    mux_mode <= 1'b1;
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h10);
    wr(8'h00, 8'hB0);
    wr(8'h00, 8'hFF);
    rdchk("chip erase ignores commands", 8'h00, 8'h00);
    wait_ready();
    wr(8'h00, 8'hFF);
    rdchk("chip erased low", 8'h05, 8'hFF);
    rdchk("chip erased high", 8'hFE, 8'hFF);
    wr(8'h00, 8'h30);
    for (int i = 0; i < 4; i++) begin
      wr(8'h60 + 8'(i), 8'h10 + 8'(i));
    end
    wait_ready();
    wr(8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      rdchk("quad byte", 8'h60 + 8'(i), 8'h10 + 8'(i));
    end
    $display("chip erase test done");
  endtask

  // reset in the middle of a block erase
  task automatic t_rst_run();
    wr(8'h00, 8'h20);
    wr(8'h80, 8'hD0);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdchk("array after mid reset", 8'h85, 8'hB9);
    wr(8'h00, 8'h70);
    rdchk("idle after mid reset", 8'h00, 8'h80);
    wr(8'h00, 8'hFF);
    $display("mid-run reset test done");
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_sig();
    t_prog();
    t_errors();
    t_berase();
    t_suspend();
    t_rst_run();
    t_chip();
    summarize();
  end
endmodule
